// ### common/fifo_info_cfg.svh
// Constants of the FIFO information and indirect MAC access register group:
// byte offsets, field positions, reset values and fixed amounts.
// Assumes a 32-bit AHB-Lite register window; only haddr[7:0] is decoded.
`ifndef FIFO_INFO_CFG_SVH
`define FIFO_INFO_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RX_FIFO_OCC_ADDR 8'h7c
`define TX_FIFO_SPACE_ADDR 8'h80
`define DROP_COUNT_ADDR 8'ha0
`define MAC_CMD_ADDR 8'ha4
`define MAC_DATA_ADDR 8'ha8
`define INT_STATUS_ADDR 8'hc0
`define INT_MASK_ADDR 8'hc4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STATUS_USED_LSB 16
`define CMD_BUSY_BIT 31
`define CMD_DIR_BIT 30
`define DROP_HALF_BIT 23

// ----------------------------------------------------------------------
// Reset values and fixed amounts
// ----------------------------------------------------------------------
`define TX_FREE_RESET 16'h1200
`define DROP_MIDPOINT 32'h7fffffff
`define DWORD_BYTES 16'h0004
`define HTRANS_NONSEQ 2'h2

`endif

// ### common/fifo_info_pkg.sv
// Types of the FIFO information and indirect MAC access register group.
// Widths are fixed; offsets and values live in fifo_info_cfg.svh.
package fifo_info_pkg;

  // --------------------------------------------------------------------
  // Indirect access sequencer
  // --------------------------------------------------------------------
  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_WAIT = 1'b1
  } access_fsm_t;

  // --------------------------------------------------------------------
  // State of the register block, apart from the FIFO level counters
  // --------------------------------------------------------------------
  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] drop_cnt;
    access_fsm_t fsm;
    logic access_direction;
    logic [7:0] cmd_index;
    logic [31:0] data_wr;
    logic [31:0] data_rd;
    logic [31:0] int_status;
    logic [31:0] int_mask;
    logic irq;
    logic mac_req;
    logic mac_wr;
    logic [7:0] mac_addr;
    logic [31:0] mac_wdata;
  } csr_state_t;

endpackage

// ### dv/host_mac_fifo_info_csr_access_tb_top.sv
// Self-checking bench: AHB-Lite host tasks, random FIFO strobes, MAC model.
// Assumes the design answers with zero wait states as its note states.
`timescale 1ns/100ps
`include "fifo_info_cfg.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module host_mac_fifo_info_csr_access_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, irq, mac_req, mac_wr, mac_ack;
  logic rx_status_push = 0, rx_status_pop = 0, rx_frame_done = 0, rx_data_pop = 0;
  logic tx_status_push = 0, tx_status_pop = 0, tx_data_push = 0, tx_data_release = 0;
  logic rx_frame_drop = 0;
  logic [15:0] rx_frame_len = 16'h0, tx_release_len = 16'h0;
  logic [7:0] mac_addr, idx;
  logic [31:0] mac_wdata, mac_rdata, r, d;
  logic [15:0] rxd = 16'h0, txf = 16'h1200, len;
  logic [7:0] rxs = 8'h0, txs = 8'h0;
  logic [31:0] drops = 32'h0;
  int errors = 0, n_compared = 0, seed = 37453;

  always #20 core_clk = ~core_clk;

  host_mac_fifo_info_csr_access host_mac_fifo_info_csr_access_inst (.core_clk(core_clk),
    .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_status_push(rx_status_push), .rx_status_pop(rx_status_pop),
    .rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len), .rx_data_pop(rx_data_pop),
    .tx_status_push(tx_status_push), .tx_status_pop(tx_status_pop),
    .tx_data_push(tx_data_push), .tx_data_release(tx_data_release),
    .tx_release_len(tx_release_len), .rx_frame_drop(rx_frame_drop), .mac_req(mac_req),
    .mac_wr(mac_wr), .mac_addr(mac_addr), .mac_wdata(mac_wdata), .mac_ack(mac_ack),
    .mac_rdata(mac_rdata), .irq(irq));

  mac_csr_model mac_csr_model_inst (.core_clk(core_clk), .rst(rst), .mac_req(mac_req),
    .mac_wr(mac_wr), .mac_addr(mac_addr), .mac_wdata(mac_wdata), .mac_ack(mac_ack),
    .mac_rdata(mac_rdata));

  // ----------------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------------
  function automatic logic [15:0] round_dword(input logic [15:0] n);
    return (n + 16'h3) & 16'hfffc;
  endfunction

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `HTRANS_NONSEQ;
    hwrite <= wr;
    do begin @(posedge core_clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge core_clk); end while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  // First poll must still see busy; a stale r would skip the wait altogether
  task automatic wait_idle;
    int k;
    k = 0;
    bus(1'b0, `MAC_CMD_ADDR, 32'h0, r);
    `CHK("busy_set", 1'b1, r[31])
    while (r[31] !== 1'b0 && k < 30) begin
      bus(1'b0, `MAC_CMD_ADDR, 32'h0, r);
      k++;
    end
    `CHK("busy", 1'b0, r[31])
  endtask

  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, `TX_FIFO_SPACE_ADDR, 32'h0, r);
    `CHK("tx_space_rst", 32'h00001200, r)
    bus(1'b0, `DROP_COUNT_ADDR, 32'h0, r);
    `CHK("drop_rst", 32'h0, r)
    bus(1'b0, `MAC_CMD_ADDR, 32'h0, r);
    `CHK("cmd_rst", 32'h0, r)
    // Random strobes; pops and pushes stay within what the FIFOs hold
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      len = (i == 0) ? 16'd61 : {5'h0, r[26:16]};
      rx_status_push <= r[0];
      rx_status_pop <= r[1] && rxs > 0;
      rx_frame_done <= r[2];
      rx_frame_len <= len;
      rx_data_pop <= r[3] && rxd >= 4;
      tx_status_push <= r[4];
      tx_status_pop <= r[5] && txs > 0;
      tx_data_push <= r[6] && txf >= 4;
      tx_data_release <= r[7] && txf <= 16'h11f0;
      tx_release_len <= {12'h0, r[13:12], 2'b0};
      rx_frame_drop <= r[10];
      // Clock enable drops now and then; a frozen cycle must leave every level alone
      ce <= r[14] | r[15];
      if (r[14] | r[15]) begin
        rxs = rxs + r[0] - (r[1] && rxs > 0);
        rxd = rxd + (r[2] ? round_dword(len) : 16'h0) - ((r[3] && rxd >= 4) ? 16'h4 : 16'h0);
        txs = txs + r[4] - (r[5] && txs > 0);
        txf = txf - ((r[6] && txf >= 4) ? 16'h4 : 16'h0)
            + ((r[7] && txf <= 16'h11f0) ? {12'h0, r[13:12], 2'b0} : 16'h0);
        drops = drops + r[10];
      end
      @(posedge core_clk);
    end
    ce <= 1'b1;
    {rx_status_push, rx_status_pop, rx_frame_done, rx_data_pop} <= 4'h0;
    {tx_status_push, tx_status_pop, tx_data_push, tx_data_release, rx_frame_drop} <= 5'h0;
    bus(1'b0, `RX_FIFO_OCC_ADDR, 32'h0, r);
    `CHK("rx_occ", {8'h0, rxs, rxd}, r)
    bus(1'b0, `TX_FIFO_SPACE_ADDR, 32'h0, r);
    `CHK("tx_space", {8'h0, txs, txf}, r)
    bus(1'b0, `DROP_COUNT_ADDR, 32'h0, r);
    `CHK("drops", drops, r)
    bus(1'b0, `DROP_COUNT_ADDR, 32'h0, r);
    `CHK("drops_cleared", 32'h0, r)
    // Indirect write, then read back the same index
    for (int i = 0; i < 3; i++) begin
      idx = $random(seed);
      d = $random(seed);
      bus(1'b1, `MAC_DATA_ADDR, d, r);
      bus(1'b1, `MAC_CMD_ADDR, 32'h80000000 | idx, r);
      wait_idle();
      bus(1'b1, `MAC_CMD_ADDR, 32'hc0000000 | idx, r);
      wait_idle();
      `CHK("cmd_read", {8'h40, 16'h0, idx}, r)
      bus(1'b1, `MAC_DATA_ADDR, ~d, r);
      bus(1'b0, `MAC_DATA_ADDR, 32'h0, r);
      `CHK("fetched", d, r)
      bus(1'b1, `MAC_CMD_ADDR, {24'h0, idx}, r);
      bus(1'b0, `MAC_DATA_ADDR, 32'h0, r);
      `CHK("host_data", ~d, r)
    end
    // Interrupt mask, status and an unmapped place
    bus(1'b1, `INT_MASK_ADDR, 32'hffffffff, r);
    bus(1'b0, `INT_MASK_ADDR, 32'h0, r);
    `CHK("mask", 32'h00800000, r)
    bus(1'b1, `INT_STATUS_ADDR, 32'hffffffff, r);
    bus(1'b0, `INT_STATUS_ADDR, 32'h0, r);
    `CHK("status", 32'h0, r)
    `CHK("irq", 1'b0, irq)
    bus(1'b0, 8'h10, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    end_of_test();
  end
endmodule

// ### dv/mac_csr_model.sv
// Behavioural model of the MAC control registers behind the indirect port.
// Assumes the requester holds mac_req and its qualifiers until mac_ack.
`timescale 1ns/100ps
module mac_csr_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mac_req,
  input wire logic mac_wr,
  input wire logic [7:0] mac_addr,
  input wire logic [31:0] mac_wdata,
  output logic mac_ack,
  output logic [31:0] mac_rdata
);
  logic [31:0] regs [256];
  int wait_cnt;
  logic slow;

  // Alternates a prompt answer with a slow one
  always_ff @(posedge core_clk) begin
    mac_ack <= 1'b0;
    if (rst) begin
      wait_cnt <= 0;
      slow <= 1'b0;
      mac_rdata <= 32'h0;
    end else begin
      // Stale read data is never left standing
      mac_rdata <= ~mac_rdata;
      if (mac_req && !mac_ack) begin
        if (wait_cnt == (slow ? 6 : 0)) begin
          mac_ack <= 1'b1;
          wait_cnt <= 0;
          slow <= ~slow;
          if (mac_wr) begin
            regs[mac_addr] <= mac_wdata;
          end else begin
            mac_rdata <= regs[mac_addr];
          end
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule

// ### hw/fifo_level_counter.sv
// Up/down level counter for one FIFO occupancy or free-space field.
// Assumes increment and decrement strobes come from logic on core_clk.
`timescale 1ns/100ps
module fifo_level_counter #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic inc_en,
  input wire logic [W-1:0] inc_amt,
  input wire logic dec_en,
  input wire logic [W-1:0] dec_amt,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] level;
  } level_state_t;

  level_state_t cur_ff;
  level_state_t nxt_cur;

  // Both strobes in one cycle net out; no saturation, the source keeps in range
  always_comb begin
    nxt_cur = cur_ff;
    if (inc_en) begin
      nxt_cur.level = nxt_cur.level + inc_amt;
    end
    if (dec_en) begin
      nxt_cur.level = nxt_cur.level - dec_amt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= '{level: INIT};
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

  assign level = cur_ff.level;
endmodule

// ### hw/host_mac_fifo_info_csr_access.sv
// FIFO information, dropped-frame counter and indirect MAC register port,
// reached by software as an AHB-Lite slave with zero wait states.
// Assumes FIFO strobes, drop pulses and the MAC port all run on core_clk.
`timescale 1ns/100ps
`include "fifo_info_cfg.svh"
module host_mac_fifo_info_csr_access (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_status_push,
  input wire logic rx_status_pop,
  input wire logic rx_frame_done,
  input wire logic [15:0] rx_frame_len,
  input wire logic rx_data_pop,
  input wire logic tx_status_push,
  input wire logic tx_status_pop,
  input wire logic tx_data_push,
  input wire logic tx_data_release,
  input wire logic [15:0] tx_release_len,
  input wire logic rx_frame_drop,
  output logic mac_req,
  output logic mac_wr,
  output logic [7:0] mac_addr,
  output logic [31:0] mac_wdata,
  input wire logic mac_ack,
  input wire logic [31:0] mac_rdata,
  output logic irq
);
  import fifo_info_pkg::*;

  csr_state_t cur_ff;
  csr_state_t nxt_cur;

  logic [7:0] rx_status_used_dwords;
  logic [15:0] rx_data_used_bytes;
  logic [7:0] tx_status_used_dwords;
  logic [15:0] tx_data_free_bytes;
  logic [15:0] rx_frame_rounded;
  logic addr_phase;
  logic drop_read;
  logic cmd_write;
  logic access_start;
  logic indirect_access_busy;

  // ----------------------------------------------------------------------
  // FIFO level fields
  // ----------------------------------------------------------------------
  assign rx_frame_rounded = (rx_frame_len + 16'h0003) & 16'hfffc;

  fifo_level_counter #(.W(8), .INIT(8'h00)) rx_status_level (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .inc_en(rx_status_push),
    .inc_amt(8'h01),
    .dec_en(rx_status_pop),
    .dec_amt(8'h01),
    .level(rx_status_used_dwords)
  );

  fifo_level_counter #(.W(16), .INIT(16'h0000)) rx_data_level (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .inc_en(rx_frame_done),
    .inc_amt(rx_frame_rounded),
    .dec_en(rx_data_pop),
    .dec_amt(`DWORD_BYTES),
    .level(rx_data_used_bytes)
  );

  fifo_level_counter #(.W(8), .INIT(8'h00)) tx_status_level (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .inc_en(tx_status_push),
    .inc_amt(8'h01),
    .dec_en(tx_status_pop),
    .dec_amt(8'h01),
    .level(tx_status_used_dwords)
  );

  // Pushes beyond the free space would wrap this field; the host prevents it
  fifo_level_counter #(.W(16), .INIT(`TX_FREE_RESET)) tx_free_level (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .inc_en(tx_data_release),
    .inc_amt(tx_release_len),
    .dec_en(tx_data_push),
    .dec_amt(`DWORD_BYTES),
    .level(tx_data_free_bytes)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Only word transfers are expected, so hsize is not decoded
  assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == 2'h3);
  assign drop_read = addr_phase && !hwrite && haddr[7:0] == `DROP_COUNT_ADDR;
  assign cmd_write = cur_ff.ap_valid && cur_ff.ap_write && cur_ff.ap_addr == `MAC_CMD_ADDR;
  assign indirect_access_busy = (cur_ff.fsm == ACC_WAIT);
  // Command and data writes while busy are dropped, so a careless host cannot corrupt an access
  assign access_start = cmd_write && !indirect_access_busy && hwdata[`CMD_BUSY_BIT];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.hreadyout = 1'b1;
    nxt_cur.hresp = 1'b0;
    nxt_cur.ap_valid = addr_phase;
    nxt_cur.ap_write = hwrite;
    nxt_cur.ap_addr = haddr[7:0];

    // Read data is latched in the address phase and stands in the data phase
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        `RX_FIFO_OCC_ADDR: begin
          nxt_cur.hrdata = {8'h00, rx_status_used_dwords, rx_data_used_bytes};
        end
        `TX_FIFO_SPACE_ADDR: begin
          nxt_cur.hrdata = {8'h00, tx_status_used_dwords, tx_data_free_bytes};
        end
        `DROP_COUNT_ADDR: begin
          nxt_cur.hrdata = cur_ff.drop_cnt;
        end
        `MAC_CMD_ADDR: begin
          nxt_cur.hrdata = {indirect_access_busy, cur_ff.access_direction, 22'h0,
                            cur_ff.cmd_index};
        end
        `MAC_DATA_ADDR: begin
          nxt_cur.hrdata = cur_ff.access_direction ? cur_ff.data_rd : cur_ff.data_wr;
        end
        `INT_STATUS_ADDR: begin
          nxt_cur.hrdata = cur_ff.int_status;
        end
        `INT_MASK_ADDR: begin
          nxt_cur.hrdata = cur_ff.int_mask;
        end
        default: begin
          nxt_cur.hrdata = 32'h00000000;
        end
      endcase
    end

    // A read in the same cycle as a drop returns the old count and keeps the drop
    if (drop_read) begin
      nxt_cur.drop_cnt = {31'h0, rx_frame_drop};
    end else if (rx_frame_drop) begin
      nxt_cur.drop_cnt = cur_ff.drop_cnt + 32'h00000001;
    end

    // Register writes land in the data phase
    if (cur_ff.ap_valid && cur_ff.ap_write) begin
      unique case (cur_ff.ap_addr)
        `MAC_CMD_ADDR: begin
          if (!indirect_access_busy) begin
            nxt_cur.access_direction = hwdata[`CMD_DIR_BIT];
            nxt_cur.cmd_index = hwdata[7:0];
          end
        end
        `MAC_DATA_ADDR: begin
          if (!indirect_access_busy) begin
            nxt_cur.data_wr = hwdata;
          end
        end
        `INT_STATUS_ADDR: begin
          nxt_cur.int_status = cur_ff.int_status & ~hwdata;
        end
        `INT_MASK_ADDR: begin
          nxt_cur.int_mask = hwdata & (32'h00000001 << `DROP_HALF_BIT);
        end
        default: begin
        end
      endcase
    end

    // Set after clear, so a crossing in the clearing cycle is not lost
    if (rx_frame_drop && !drop_read && cur_ff.drop_cnt == `DROP_MIDPOINT) begin
      nxt_cur.int_status[`DROP_HALF_BIT] = 1'b1;
    end

    // Indirect access sequencer
    unique case (cur_ff.fsm)
      ACC_IDLE: begin
        if (access_start) begin
          nxt_cur.fsm = ACC_WAIT;
          nxt_cur.mac_req = 1'b1;
          nxt_cur.mac_wr = !hwdata[`CMD_DIR_BIT];
          nxt_cur.mac_addr = hwdata[7:0];
          nxt_cur.mac_wdata = cur_ff.data_wr;
        end
      end
      ACC_WAIT: begin
        if (mac_ack) begin
          nxt_cur.fsm = ACC_IDLE;
          nxt_cur.mac_req = 1'b0;
          if (!cur_ff.mac_wr) begin
            nxt_cur.data_rd = mac_rdata;
          end
        end
      end
    endcase

    nxt_cur.irq = |(nxt_cur.int_status & nxt_cur.int_mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= '{
        ap_valid: 1'b0,
        ap_write: 1'b0,
        ap_addr: 8'h00,
        hreadyout: 1'b1,
        hresp: 1'b0,
        hrdata: 32'h00000000,
        drop_cnt: 32'h00000000,
        fsm: ACC_IDLE,
        access_direction: 1'b0,
        cmd_index: 8'h00,
        data_wr: 32'h00000000,
        data_rd: 32'h00000000,
        int_status: 32'h00000000,
        int_mask: 32'h00000000,
        irq: 1'b0,
        mac_req: 1'b0,
        mac_wr: 1'b0,
        mac_addr: 8'h00,
        mac_wdata: 32'h00000000
      };
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

  assign hreadyout = cur_ff.hreadyout;
  assign hresp = cur_ff.hresp;
  assign hrdata = cur_ff.hrdata;
  assign mac_req = cur_ff.mac_req;
  assign mac_wr = cur_ff.mac_wr;
  assign mac_addr = cur_ff.mac_addr;
  assign mac_wdata = cur_ff.mac_wdata;
  assign irq = cur_ff.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  rx_status_count_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && rx_status_push && !rx_status_pop |=>
      rx_status_used_dwords == $past(rx_status_used_dwords) + 8'h01)
    else $error("rx status level did not step up");

  rx_data_round_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && rx_frame_done && !rx_data_pop |=>
      rx_data_used_bytes == $past(rx_data_used_bytes) + $past(rx_frame_rounded)
      && rx_data_used_bytes[1:0] == $past(rx_data_used_bytes[1:0]))
    else $error("rx data level not grown by rounded length");

  tx_status_count_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && tx_status_pop && !tx_status_push |=>
      tx_status_used_dwords == $past(tx_status_used_dwords) - 8'h01)
    else $error("tx status level did not step down");

  tx_free_reset_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(rst) |-> tx_data_free_bytes == `TX_FREE_RESET)
    else $error("tx free space not full after reset");

  drop_count_step_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && rx_frame_drop && !drop_read |=> cur_ff.drop_cnt == $past(cur_ff.drop_cnt) + 32'h1)
    else $error("dropped frame not counted");

  drop_read_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && drop_read && !rx_frame_drop |=>
      cur_ff.drop_cnt == 32'h0 && hrdata == $past(cur_ff.drop_cnt))
    else $error("drop counter read did not return and clear");

  drop_halfway_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && rx_frame_drop && !drop_read && cur_ff.drop_cnt == `DROP_MIDPOINT |=>
      cur_ff.int_status[`DROP_HALF_BIT] && irq == cur_ff.int_mask[`DROP_HALF_BIT])
    else $error("halfway flag not raised");

  busy_done_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && indirect_access_busy && mac_ack && !mac_wr |=>
      !indirect_access_busy && cur_ff.data_rd == $past(mac_rdata))
    else $error("read access ended without data");

  start_capture_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && access_start |=> indirect_access_busy && mac_req
      && mac_addr == $past(hwdata[7:0]) && mac_wr == !$past(hwdata[`CMD_DIR_BIT])
      && mac_wdata == $past(cur_ff.data_wr))
    else $error("access start not captured");
endmodule
